// ===== dau_consts.svh
// register offsets, field positions, reset values for the converter front end
`ifndef DAU_CONSTS_SVH
`define DAU_CONSTS_SVH

// ==========================================
// register offsets, first channel
`define DAU_CH0_LOW_ADDR 8'hD2
`define DAU_CH0_HIGH_ADDR 8'hD3
`define DAU_CH0_CTRL_ADDR 8'hD4

// ==========================================
// register offsets, second channel
`define DAU_CH1_LOW_ADDR 8'hD5
`define DAU_CH1_HIGH_ADDR 8'hD6
`define DAU_CH1_CTRL_ADDR 8'hD7

// ==========================================
// control register fields
`define DAU_CTRL_ON_BIT 7
`define DAU_CTRL_SRC_HI 4
`define DAU_CTRL_SRC_LO 3
`define DAU_CTRL_FMT_HI 2
`define DAU_CTRL_FMT_LO 0
`define DAU_CTRL_WMASK 8'h9F

// ==========================================
// reset values and idle answers
`define DAU_LOW_RESET 8'h00
`define DAU_HIGH_RESET 8'h00
`define DAU_CTRL_RESET 8'h00
`define DAU_CODE_RESET 12'h000
`define DAU_UNMAPPED_READ 8'h00

`endif

// ===== dau_pkg.sv
// types shared by the converter front end
package dau_pkg;

  // ==========================================
  // update trigger encoding of the source field
  typedef enum logic [1:0] {
    DAU_SRC_WRITE = 2'b00,
    DAU_SRC_T3 = 2'b01,
    DAU_SRC_T4 = 2'b10,
    DAU_SRC_T2 = 2'b11
  } dau_src_t;

  // justification select field
  typedef logic [2:0] dau_fmt_t;

  // one register byte
  typedef logic [7:0] dau_byte_t;

  // converter input code
  typedef logic [11:0] dau_code_t;

endpackage

// ===== dau_justify.sv
// unpacks the 12-bit converter code from the two data bytes
`timescale 1ns/1ps
`include "dau_consts.svh"

module dau_justify
  import dau_pkg::*;
(
  input wire dau_byte_t low,
  input wire dau_byte_t high,
  input wire dau_fmt_t fmt,
  output dau_code_t code
);

  // ==========================================
  // format decode, top bit overrides the rest
  always_comb begin
    code = `DAU_CODE_RESET;
    if (fmt[2]) begin
      code = {high, low[7:4]}; // RQ13
    end else begin
      unique case (fmt[1:0])
        2'b00: code = {high[3:0], low}; // RQ9
        2'b01: code = {high[4:0], low[7:1]}; // RQ10
        2'b10: code = {high[5:0], low[7:2]}; // RQ11
        2'b11: code = {high[6:0], low[7:3]}; // RQ12
      endcase
    end
  end

endmodule

// ===== dau_top.sv
// two-channel converter front end: data and control registers, update trigger, latch
`timescale 1ns/1ps
`include "dau_consts.svh"

// How it works
// RQ1 - each channel latches an unsigned 12-bit code, 0x000 to 0xFFF, for the converter
// RQ2 - control bit 7 switches the channel on; zero means low-power shutdown
// RQ3 - while switched off the output enable line stays inactive
// RQ4 - reading the low byte returns the last value written, not the latch
// RQ5 - reading the high byte returns the high-byte input latch
// RQ6 - control bits 4:3 pick trigger: high write, timer 3, timer 4, timer 2
// RQ7 - in write mode a low write is held until the next high write
// RQ8 - in timer mode both bytes are held and copied on the chosen overflow
// RQ9 - format 000: high bits 3:0 above the whole low byte
// RQ10 - format 001: high bits 4:0 above low bits 7:1
// RQ11 - format 010: high bits 5:0 above low bits 7:2
// RQ12 - format 011: high bits 6:0 above low bits 7:3
// RQ13 - format 1xx: whole high byte above low bits 7:4
// RQ14 - control bits 6:5 read as zero and ignore writes
// RQ15 - a second channel behaves identically with its own registers
// RQ16 - software writes low byte first, then high byte, for full resolution
// RQ17 - for 8-bit use software loads the low byte once, then high only
// RQ18 - a timer mode reacts only to its own timer, not to high writes
// RQ19 - switching off keeps the data registers and the latched code
module dau_top
  import dau_pkg::*;
#(
  parameter int NUM_CH = 2
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  output logic [7:0] RDATA,
  input wire logic T2_OVF,
  input wire logic T3_OVF,
  input wire logic T4_OVF,
  output logic [11:0] CONV0_CODE,
  output logic CONV0_OUT_EN,
  output logic CONV0_POWER_ON,
  output logic CONV0_UPDATED,
  output logic [11:0] CONV1_CODE,
  output logic CONV1_OUT_EN,
  output logic CONV1_POWER_ON,
  output logic CONV1_UPDATED
);

  // ==========================================
  // per-channel storage
  dau_byte_t low_hold [NUM_CH];
  dau_byte_t high_hold [NUM_CH];
  dau_byte_t high_latch [NUM_CH];
  dau_byte_t ctrl [NUM_CH];
  dau_code_t code [NUM_CH];
  logic [NUM_CH-1:0] updated;

  // per-channel decode and trigger terms
  logic [NUM_CH-1:0] wr_low;
  logic [NUM_CH-1:0] wr_high;
  logic [NUM_CH-1:0] wr_ctrl;
  logic [NUM_CH-1:0] hit_low;
  logic [NUM_CH-1:0] hit_high;
  logic [NUM_CH-1:0] hit_ctrl;
  logic [NUM_CH-1:0] trigger;
  dau_byte_t src_low [NUM_CH];
  dau_byte_t src_high [NUM_CH];
  dau_code_t next_code [NUM_CH];
  dau_byte_t read_value [NUM_CH];
  logic [NUM_CH-1:0] read_hit;

  // ==========================================
  // channel slices, one per converter
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch // RQ15
      localparam logic [7:0] LOW_ADDR =
        (ch == 0) ? `DAU_CH0_LOW_ADDR : `DAU_CH1_LOW_ADDR;
      localparam logic [7:0] HIGH_ADDR =
        (ch == 0) ? `DAU_CH0_HIGH_ADDR : `DAU_CH1_HIGH_ADDR;
      localparam logic [7:0] CTRL_ADDR =
        (ch == 0) ? `DAU_CH0_CTRL_ADDR : `DAU_CH1_CTRL_ADDR;

      dau_src_t src_sel;
      dau_fmt_t fmt_sel;

      // address decode for this channel
      assign hit_low[ch] = (ADDR == LOW_ADDR);
      assign hit_high[ch] = (ADDR == HIGH_ADDR);
      assign hit_ctrl[ch] = (ADDR == CTRL_ADDR);
      assign wr_low[ch] = WE && hit_low[ch];
      assign wr_high[ch] = WE && hit_high[ch];
      assign wr_ctrl[ch] = WE && hit_ctrl[ch];

      // control fields as typed values
      assign src_sel = dau_src_t'(ctrl[ch][`DAU_CTRL_SRC_HI:`DAU_CTRL_SRC_LO]);
      assign fmt_sel = ctrl[ch][`DAU_CTRL_FMT_HI:`DAU_CTRL_FMT_LO];

      // update trigger chosen by the source field
      always_comb begin
        trigger[ch] = 1'b0;
        unique case (src_sel) // RQ6
          DAU_SRC_WRITE: trigger[ch] = wr_high[ch]; // RQ7
          DAU_SRC_T3: trigger[ch] = T3_OVF; // RQ18
          DAU_SRC_T4: trigger[ch] = T4_OVF; // RQ18
          DAU_SRC_T2: trigger[ch] = T2_OVF; // RQ18
        endcase
      end

      // bytes handed to the latch; a same-cycle write is included
      assign src_low[ch] = wr_low[ch] ? WDATA : low_hold[ch];
      assign src_high[ch] = wr_high[ch] ? WDATA : high_hold[ch];

      // unpack the held bytes into the code
      dau_justify u_justify (
        .low(src_low[ch]),
        .high(src_high[ch]),
        .fmt(fmt_sel),
        .code(next_code[ch])
      );

      // low byte holding register, never cleared by switching off
      always_ff @(posedge CLK) begin
        if (RESET) begin
          low_hold[ch] <= `DAU_LOW_RESET;
        end else if (wr_low[ch]) begin
          low_hold[ch] <= WDATA; // RQ4
        end
      end

      // high byte holding register
      always_ff @(posedge CLK) begin
        if (RESET) begin
          high_hold[ch] <= `DAU_HIGH_RESET;
        end else if (wr_high[ch]) begin
          high_hold[ch] <= WDATA; // RQ8
        end
      end

      // control register, unused bits forced to zero
      always_ff @(posedge CLK) begin
        if (RESET) begin
          ctrl[ch] <= `DAU_CTRL_RESET;
        end else if (wr_ctrl[ch]) begin
          ctrl[ch] <= WDATA & `DAU_CTRL_WMASK; // RQ14
        end
      end

      // input latch: high byte image and unpacked code
      always_ff @(posedge CLK) begin
        if (RESET) begin
          high_latch[ch] <= `DAU_HIGH_RESET;
          code[ch] <= `DAU_CODE_RESET;
        end else if (trigger[ch]) begin
          high_latch[ch] <= src_high[ch]; // RQ8
          code[ch] <= next_code[ch]; // RQ1
        end
      end

      // one-cycle marker after each latch update
      always_ff @(posedge CLK) begin
        if (RESET) begin
          updated[ch] <= 1'b0;
        end else begin
          updated[ch] <= trigger[ch];
        end
      end

      // read view of this channel
      always_comb begin
        read_hit[ch] = 1'b1;
        read_value[ch] = `DAU_UNMAPPED_READ;
        if (hit_low[ch]) begin
          read_value[ch] = low_hold[ch]; // RQ4
        end else if (hit_high[ch]) begin
          read_value[ch] = high_latch[ch]; // RQ5
        end else if (hit_ctrl[ch]) begin
          read_value[ch] = ctrl[ch] & `DAU_CTRL_WMASK; // RQ14
        end else begin
          read_hit[ch] = 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================
  // register read port
  dau_byte_t next_rdata;

  // merge the channel read views; unmapped reads give zero
  always_comb begin
    next_rdata = `DAU_UNMAPPED_READ;
    for (int i = 0; i < NUM_CH; i++) begin
      if (read_hit[i]) begin
        next_rdata = read_value[i];
      end
    end
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA <= `DAU_UNMAPPED_READ;
    end else if (RE) begin
      RDATA <= next_rdata;
    end
  end

  // ==========================================
  // converter-facing outputs
  // code stays latched while off, so re-enabling restores it
  assign CONV0_CODE = code[0]; // RQ19
  assign CONV1_CODE = code[1]; // RQ19

  // power and output enable follow the on bit
  assign CONV0_POWER_ON = ctrl[0][`DAU_CTRL_ON_BIT]; // RQ2
  assign CONV1_POWER_ON = ctrl[1][`DAU_CTRL_ON_BIT]; // RQ2
  assign CONV0_OUT_EN = ctrl[0][`DAU_CTRL_ON_BIT]; // RQ3
  assign CONV1_OUT_EN = ctrl[1][`DAU_CTRL_ON_BIT]; // RQ3

  // update markers
  assign CONV0_UPDATED = updated[0];
  assign CONV1_UPDATED = updated[1];

endmodule

// ===== dau_checker.sv
// assertions on the converter front end ports
`timescale 1ns/1ps
`include "dau_consts.svh"
module dau_checker
  import dau_pkg::*;
#(
  parameter int NUM_CH = 2
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  input wire logic [7:0] RDATA,
  input wire logic T2_OVF,
  input wire logic T3_OVF,
  input wire logic T4_OVF,
  input wire logic [11:0] CONV0_CODE,
  input wire logic CONV0_OUT_EN,
  input wire logic CONV0_POWER_ON,
  input wire logic CONV0_UPDATED,
  input wire logic CONV1_OUT_EN
);
  dau_byte_t ctl, ctl1, lo, hi, lat, next_lo, next_hi;
  dau_code_t next_code;
  logic trig;
  // held bytes, selected trigger and shifted code
  always_comb begin
    next_lo = (WE && ADDR == `DAU_CH0_LOW_ADDR) ? WDATA : lo;
    next_hi = (WE && ADDR == `DAU_CH0_HIGH_ADDR) ? WDATA : hi;
    trig = (ctl[4:3] == 2'h0) ? (WE && ADDR == `DAU_CH0_HIGH_ADDR) :
      (ctl[4:3] == 2'h1) ? T3_OVF : (ctl[4:3] == 2'h2) ? T4_OVF : T2_OVF;
    next_code = 12'({next_hi, next_lo} >> (ctl[2] ? 3'h4 : {1'b0, ctl[1:0]}));
  end
  // shadow of what software wrote
  always_ff @(posedge CLK) begin
    if (RESET) begin
      {ctl, ctl1, lo, hi, lat} <= '0;
    end else begin
      if (WE && ADDR == `DAU_CH0_CTRL_ADDR) ctl <= WDATA & `DAU_CTRL_WMASK;
      if (WE && ADDR == `DAU_CH1_CTRL_ADDR) ctl1 <= WDATA & `DAU_CTRL_WMASK;
      lo <= next_lo;
      hi <= next_hi;
      if (trig) lat <= next_hi;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  AST_ON: assert property (CONV0_OUT_EN == ctl[7])
    else $error("enable differs from on bit");
  AST_HIZ: assert property (!ctl[7] |-> !CONV0_OUT_EN && !CONV0_POWER_ON)
    else $error("output driven while off");
  AST_UPD: assert property (trig |=> CONV0_UPDATED && CONV0_CODE == $past(next_code))
    else $error("latch not loaded on trigger");
  AST_HOLD: assert property (!trig |=> !CONV0_UPDATED && $stable(CONV0_CODE))
    else $error("code moved without trigger");
  AST_LOW_RD: assert property (RE && ADDR == `DAU_CH0_LOW_ADDR |=> RDATA == $past(lo))
    else $error("low read wrong");
  AST_HIGH_RD: assert property (RE && ADDR == `DAU_CH0_HIGH_ADDR |=> RDATA == $past(lat))
    else $error("high read wrong");
  AST_CTL_RD: assert property (RE && ADDR == `DAU_CH0_CTRL_ADDR |=> RDATA == $past(ctl))
    else $error("control read wrong");
  AST_CH1_ON: assert property (CONV1_OUT_EN == ctl1[7])
    else $error("second enable wrong");
endmodule

bind dau_top dau_checker #(.NUM_CH(NUM_CH)) u_chk (.*);

// ===== dau_host.sv
// processor side: register bus cycles and timer overflow pulses
`timescale 1ns/1ps
module dau_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic we,
  output logic re,
  output logic [2:0] ovf
);
  // idle bus from time zero
  initial begin
    {addr, wdata, we, re, ovf} = '0;
  end
  // one write; data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    wdata <= ~d;
    #1;
  endtask
  // one read, data taken after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask
  // one-cycle overflow pulse: bit 0 timer 2, bit 1 timer 3, bit 2 timer 4
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    ovf <= v;
    @(posedge clk);
    ovf <= 3'h0;
    #1;
  endtask
endmodule

// ===== tb.sv
// self-checking bench for the converter front end
`timescale 1ns/1ps
`include "dau_consts.svh"
module tb;
  import dau_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr, wdata, rdata;
  logic we, re, en0, en1, upd1, pw0, pw1;
  logic [2:0] ovf, sel, fmt;
  dau_code_t code0, code1, exp0;
  dau_byte_t lo, hi, ph, rd;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 32'hbf13_9979;
  always #20 clk = ~clk;
  dau_host u_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .ovf(ovf));
  dau_top DUT (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WE(we), .RE(re),
    .RDATA(rdata), .T2_OVF(ovf[0]), .T3_OVF(ovf[1]), .T4_OVF(ovf[2]), .CONV0_CODE(code0),
    .CONV0_OUT_EN(en0), .CONV0_POWER_ON(pw0), .CONV0_UPDATED(), .CONV1_CODE(code1),
    .CONV1_OUT_EN(en1), .CONV1_POWER_ON(pw1), .CONV1_UPDATED(upd1));
  // code from bytes for each justification
  function automatic dau_code_t want_code(dau_byte_t l, dau_byte_t h, logic [2:0] f);
    if (f[2]) return {h, l[7:4]};
    case (f[1:0])
      2'h0: return {h[3:0], l};
      2'h1: return {h[4:0], l[7:1]};
      2'h2: return {h[5:0], l[7:2]};
      default: return {h[6:0], l[7:3]};
    endcase
  endfunction
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    ph = 8'h00;
    // reset values, then an unmapped address
    for (int a = 0; a < 4; a++) begin
      u_host.rd(`DAU_CH0_LOW_ADDR + 8'(a * 2), rd);
      check(rd, 12'h000);
    end
    // every mode with every justification
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 5; f++) begin
        fmt = (f == 4) ? (3'h4 | 3'($random(seed))) : 3'(f);
        u_host.wr(`DAU_CH0_CTRL_ADDR, {1'b1, 2'h3, 2'(m), fmt});
        u_host.rd(`DAU_CH0_CTRL_ADDR, rd);
        check(rd, {1'b1, 2'h0, 2'(m), fmt});
        check(en0, 1'b1);
        lo = 8'($random(seed));
        hi = 8'($random(seed));
        if (f == 0) lo = {8{m[0]}};
        if (f == 0) hi = lo;
        exp0 = code0;
        u_host.wr(`DAU_CH0_LOW_ADDR, lo);
        check(code0, exp0);
        u_host.rd(`DAU_CH0_LOW_ADDR, rd);
        check(rd, lo);
        u_host.wr(`DAU_CH0_HIGH_ADDR, hi);
        if (m != 0) begin
          check(code0, exp0);
          u_host.rd(`DAU_CH0_HIGH_ADDR, rd);
          check(rd, ph);
          sel = (m == 1) ? 3'h2 : (m == 2) ? 3'h4 : 3'h1;
          u_host.pulse({sel[1:0], sel[2]});
          check(code0, exp0);
          u_host.pulse(sel);
        end
        check(code0, want_code(lo, hi, fmt));
        u_host.rd(`DAU_CH0_HIGH_ADDR, rd);
        check(rd, hi);
        ph = hi;
      end
    end
    // switch off: output released, code kept
    exp0 = code0;
    u_host.wr(`DAU_CH0_CTRL_ADDR, 8'h00);
    check(en0, 1'b0);
    check(pw0, 1'b0);
    check(code0, exp0);
    // second channel in 8-bit use
    u_host.wr(`DAU_CH1_CTRL_ADDR, 8'h84);
    u_host.wr(`DAU_CH1_LOW_ADDR, 8'h00);
    repeat (2) begin
      hi = 8'($random(seed));
      u_host.wr(`DAU_CH1_HIGH_ADDR, hi);
      check(code1, {hi, 4'h0});
      check(upd1, 1'b1);
    end
    check(en1, 1'b1);
    check(pw1, 1'b1);
    check(code0, exp0);
    conclude();
  end
endmodule
